// ==== core/pwm_shadow_sync_update.v ====
// Top of the PWM group: APB slave, group control and four channels
`timescale 1ns/1ps
`default_nettype none
`include "pwm_sync_map.vh"
//
// Contract
// RQ1 - Every channel has host-accessible period and duty shadows beside its two compares.
// RQ2 - With updates enabled, shadows move into the compares only at the next period start.
// RQ3 - Software changes period or duty glitch-free by writing shadows, not compares.
// RQ4 - The clock select shadow lands at the same period boundary as the compare shadows.
// RQ5 - An update-enable field written 01 disables and written 10 enables that channel.
// RQ6 - Writing 00 or 11 to an update-enable field leaves it unchanged.
// RQ7 - An update-enable field reads 00 when disabled and 11 when enabled.
// RQ8 - Enabling updates together with the host trigger loads all shadows at once.
// RQ9 - The master channel with trigger output set restarts the followers each period.
// RQ10 - Software sets followers to continuous mode, high level and reset on trigger.
// RQ11 - Software enables the outputs of used channels via output and channel enables.
// RQ12 - Shadow writes to one channel change only that channel at its next boundary.
// RQ13 - With the routed variant, shadow values come from a routing unit word.
// RQ14 - Software initialises the master compares and shadows and clears its counter.
// RQ15 - Duty compare holds the duty count and period compare the period count.
// RQ16 - A follower with reset on trigger restarts its counter on the master trigger.
// RQ17 - Output is active below duty compare and the counter wraps at period compare.
module pwm_shadow_sync_update (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire route_valid,
  input wire [1:0] route_channel,
  input wire [31:0] route_word,
  output wire route_ready,
  output reg [`NUM_CH-1:0] pwm_out
);
  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire wr = psel && penable && pwrite;
  wire in_ch = (paddr >= `CH_BASE) && (paddr < (`CH_BASE + `NUM_CH * `CH_STRIDE));
  wire [11:0] ch_off = paddr - `CH_BASE;
  wire [1:0] ch_sel = ch_off[6:5];
  wire [4:0] ch_reg = ch_off[4:0];
  wire grp_hit = (paddr == `GRP_GLOBAL) || (paddr == `GRP_OUTPUT_ENABLE_FIELD) ||
    (paddr == `GRP_CHANNEL_ENABLE_FIELD) || (paddr == `GRP_ROUTE);
  wire mapped = in_ch || grp_hit;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ---------------------------------------------------------------
  // Group control state
  // ---------------------------------------------------------------
  reg [`NUM_CH-1:0] update_en;
  reg [`NUM_CH-1:0] output_en;
  reg [`NUM_CH-1:0] channel_en;
  reg [`NUM_CH-1:0] route_en;
  reg force_update;
  reg [31:0] ctrl [0:`NUM_CH-1];
  wire [7:0] tick;
  wire [`NUM_CH-1:0] period_start;
  wire [`NUM_CH-1:0] level;
  wire [`NUM_CH*`CNT_W-1:0] pc_bus, dc_bus, ps_bus, ds_bus, cn_bus;
  wire [`NUM_CH*`CLKSEL_W-1:0] cs_bus, css_bus;
  wire [31:0] glb_word = pwdata;
  reg [`NUM_CH-1:0] trigger_out;
  reg trigger_line;
  // One loop variable per process, so no two processes share a driver
  integer k;
  integer c;
  integer t;
  integer r;

  assign route_ready = 1'b1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      update_en <= {`NUM_CH{1'b0}};
      output_en <= {`NUM_CH{1'b0}};
      channel_en <= {`NUM_CH{1'b0}};
      route_en <= {`NUM_CH{1'b0}};
      force_update <= 1'b0;
    end else begin
      force_update <= 1'b0;
      if (wr && paddr == `GRP_GLOBAL) begin
        for (k = 0; k < `NUM_CH; k = k + 1) begin
          // 01 disables, 10 enables, 00 and 11 leave the field alone
          case (glb_word[`GLB_UPEN_LSB + 2*k +: 2])
            2'b01: update_en[k] <= 1'b0; // RQ5
            2'b10: update_en[k] <= 1'b1; // RQ5
            default: update_en[k] <= update_en[k]; // RQ6
          endcase
        end
        force_update <= glb_word[`GLB_HOSTTRIG_BIT]; // RQ8
      end
      if (wr && paddr == `GRP_OUTPUT_ENABLE_FIELD) begin
        for (k = 0; k < `NUM_CH; k = k + 1) begin
          case (pwdata[2*k +: 2])
            2'b01: output_en[k] <= 1'b0;
            2'b10: output_en[k] <= 1'b1;
            default: output_en[k] <= output_en[k];
          endcase
        end
      end
      if (wr && paddr == `GRP_CHANNEL_ENABLE_FIELD) begin
        for (k = 0; k < `NUM_CH; k = k + 1) begin
          case (pwdata[2*k +: 2])
            2'b01: channel_en[k] <= 1'b0;
            2'b10: channel_en[k] <= 1'b1;
            default: channel_en[k] <= channel_en[k];
          endcase
        end
      end
      if (wr && paddr == `GRP_ROUTE) route_en <= pwdata[`NUM_CH-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Master trigger
  // ---------------------------------------------------------------
  // Every channel with trigger output set drives the line; their period starts are ORed
  always @* begin
    trigger_line = 1'b0;
    for (t = 0; t < `NUM_CH; t = t + 1) begin
      trigger_out[t] = ctrl[t][`CTRL_TRIGOUT_BIT] && period_start[t];
      trigger_line = trigger_line | trigger_out[t]; // RQ9
    end
  end

  // Control words and outputs of all channels in one process
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (c = 0; c < `NUM_CH; c = c + 1) begin
        ctrl[c] <= `CTRL_RESET;
      end
      pwm_out <= {`NUM_CH{1'b0}};
    end else begin
      for (c = 0; c < `NUM_CH; c = c + 1) begin
        if (wr && in_ch && ch_sel == c && ch_reg == `CH_CTRL) ctrl[c] <= pwdata;
      end
      pwm_out <= output_en & level;
    end
  end

  pwm_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `NUM_CH; g = g + 1) begin : gen_ch
      wire hit = wr && in_ch && (ch_sel == g);
      wire rv = route_valid && route_en[g] && (route_channel == g);

      pwm_channel u_ch (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .wr_data(pwdata[`CNT_W-1:0]),
        .wr_period(hit && ch_reg == `CH_PERIOD),
        .wr_duty(hit && ch_reg == `CH_DUTY),
        .wr_pshadow(hit && ch_reg == `CH_PSHADOW),
        .wr_dshadow(hit && ch_reg == `CH_DSHADOW),
        .wr_counter(hit && ch_reg == `CH_COUNTER),
        .wr_clksel(hit && ch_reg == `CH_CLKSEL),
        .wr_clkshadow(hit && ch_reg == `CH_CLKSHADOW),
        .route_valid(rv),
        .route_word(route_word),
        .update_en(update_en[g]),
        .force_update(force_update),
        .level_high(ctrl[g][`CTRL_LEVEL_BIT]),
        .reset_on_trigger(ctrl[g][`CTRL_RSTTRIG_BIT] && !trigger_out[g]),
        .trigger_in(trigger_line),
        .run(channel_en[g]),
        .period_compare(pc_bus[g*`CNT_W +: `CNT_W]),
        .duty_compare(dc_bus[g*`CNT_W +: `CNT_W]),
        .period_shadow(ps_bus[g*`CNT_W +: `CNT_W]),
        .duty_shadow(ds_bus[g*`CNT_W +: `CNT_W]),
        .channel_counter(cn_bus[g*`CNT_W +: `CNT_W]),
        .clock_select(cs_bus[g*`CLKSEL_W +: `CLKSEL_W]),
        .clock_select_shadow(css_bus[g*`CLKSEL_W +: `CLKSEL_W]),
        .period_start(period_start[g]),
        .pwm_level(level[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  reg [31:0] next_prdata;
  always @* begin
    next_prdata = 32'h00000000;
    if (paddr == `GRP_GLOBAL) begin
      for (r = 0; r < `NUM_CH; r = r + 1) begin
        next_prdata[`GLB_UPEN_LSB + 2*r +: 2] = {2{update_en[r]}}; // RQ7
      end
    end else if (paddr == `GRP_OUTPUT_ENABLE_FIELD) begin
      for (r = 0; r < `NUM_CH; r = r + 1) next_prdata[2*r +: 2] = {2{output_en[r]}};
    end else if (paddr == `GRP_CHANNEL_ENABLE_FIELD) begin
      for (r = 0; r < `NUM_CH; r = r + 1) next_prdata[2*r +: 2] = {2{channel_en[r]}};
    end else if (paddr == `GRP_ROUTE) begin
      next_prdata[`NUM_CH-1:0] = route_en;
    end else if (in_ch) begin
      case (ch_reg)
        `CH_CTRL: next_prdata = ctrl[ch_sel];
        `CH_PERIOD: next_prdata[`CNT_W-1:0] = pc_bus[ch_sel*`CNT_W +: `CNT_W];
        `CH_DUTY: next_prdata[`CNT_W-1:0] = dc_bus[ch_sel*`CNT_W +: `CNT_W];
        `CH_PSHADOW: next_prdata[`CNT_W-1:0] = ps_bus[ch_sel*`CNT_W +: `CNT_W]; // RQ1
        `CH_DSHADOW: next_prdata[`CNT_W-1:0] = ds_bus[ch_sel*`CNT_W +: `CNT_W]; // RQ1
        `CH_COUNTER: next_prdata[`CNT_W-1:0] = cn_bus[ch_sel*`CNT_W +: `CNT_W];
        `CH_CLKSEL: next_prdata[`CLKSEL_W-1:0] = cs_bus[ch_sel*`CLKSEL_W +: `CLKSEL_W];
        `CH_CLKSHADOW: next_prdata[`CLKSEL_W-1:0] = css_bus[ch_sel*`CLKSEL_W +: `CLKSEL_W];
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  // Read data registered in setup so it is stable in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end
endmodule // pwm_shadow_sync_update
`default_nettype wire

// ==== inc/pwm_sync_map.vh ====
// Register map, field positions and reset values of the PWM shadow update block
`ifndef PWM_SYNC_MAP_VH
`define PWM_SYNC_MAP_VH
`define NUM_CH 4
`define CNT_W 16
`define CLKSEL_W 3
// Per-channel register window: channel n at base + n * stride
`define CH_BASE 12'h100
`define CH_STRIDE 12'h020
`define CH_CTRL 5'h00
`define CH_PERIOD 5'h04
`define CH_DUTY 5'h08
`define CH_PSHADOW 5'h0c
`define CH_DSHADOW 5'h10
`define CH_COUNTER 5'h14
`define CH_CLKSEL 5'h18
`define CH_CLKSHADOW 5'h1c
// Group registers
`define GRP_GLOBAL 12'h000
`define GRP_OUTPUT_ENABLE_FIELD 12'h004
`define GRP_CHANNEL_ENABLE_FIELD 12'h008
`define GRP_ROUTE 12'h00c
// Channel control fields
// Level bit is the one both the master and the follower control words set
`define CTRL_LEVEL_BIT 12
`define CTRL_RSTTRIG_BIT 20
`define CTRL_TRIGOUT_BIT 24
// Group global control fields
`define GLB_HOSTTRIG_BIT 0
`define GLB_UPEN_LSB 16
// Reset values
`define CTRL_RESET 32'h00000000
`define CMP_RESET 16'h0000
`define CLKSEL_RESET 3'h0
`endif

// ==== core/pwm_prescaler.v ====
// Shared prescaler producing the selectable channel count enables
`timescale 1ns/1ps
`default_nettype none
module pwm_prescaler (
  input wire pclk,
  input wire presetn,
  output reg [7:0] tick
);
  reg [7:0] div;
  integer i;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 8'h00;
    end else begin
      div <= div + 8'h01;
    end
  end

  // Select k pulses once every 2**k clocks
  always @* begin
    tick[0] = 1'b1;
    for (i = 1; i < 8; i = i + 1) begin
      tick[i] = (div & ((8'h01 << i) - 8'h01)) == 8'h00;
    end
  end
endmodule // pwm_prescaler
`default_nettype wire

// ==== core/pwm_channel.v ====
// One PWM channel: active compares, shadows, counter and output
`timescale 1ns/1ps
`default_nettype none
`include "pwm_sync_map.vh"
module pwm_channel (
  input wire pclk,
  input wire presetn,
  input wire [7:0] tick,
  input wire [`CNT_W-1:0] wr_data,
  input wire wr_period,
  input wire wr_duty,
  input wire wr_pshadow,
  input wire wr_dshadow,
  input wire wr_counter,
  input wire wr_clksel,
  input wire wr_clkshadow,
  input wire route_valid,
  input wire [2*`CNT_W-1:0] route_word,
  input wire update_en,
  input wire force_update,
  input wire level_high,
  input wire reset_on_trigger,
  input wire trigger_in,
  input wire run,
  output reg [`CNT_W-1:0] period_compare,
  output reg [`CNT_W-1:0] duty_compare,
  output reg [`CNT_W-1:0] period_shadow,
  output reg [`CNT_W-1:0] duty_shadow,
  output reg [`CNT_W-1:0] channel_counter,
  output reg [`CLKSEL_W-1:0] clock_select,
  output reg [`CLKSEL_W-1:0] clock_select_shadow,
  output wire period_start,
  output reg pwm_level
);
  wire step = run && tick[clock_select];
  wire wrap = step && (channel_counter >= period_compare);
  wire restart = (reset_on_trigger && trigger_in) || wrap;
  wire load = force_update || (update_en && restart);
  assign period_start = wrap;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_compare <= `CMP_RESET;
      duty_compare <= `CMP_RESET;
      period_shadow <= `CMP_RESET;
      duty_shadow <= `CMP_RESET;
      channel_counter <= `CMP_RESET;
      clock_select <= `CLKSEL_RESET;
      clock_select_shadow <= `CLKSEL_RESET;
      pwm_level <= 1'b0;
    end else begin
      if (route_valid) begin
        period_shadow <= route_word[`CNT_W-1:0]; // RQ13
        duty_shadow <= route_word[2*`CNT_W-1:`CNT_W]; // RQ13
      end else begin
        if (wr_pshadow) period_shadow <= wr_data; // RQ1 RQ12
        if (wr_dshadow) duty_shadow <= wr_data; // RQ1 RQ12
      end
      if (wr_clkshadow) clock_select_shadow <= wr_data[`CLKSEL_W-1:0];
      // Shadows land only at a period boundary or on a forced trigger
      if (load) begin
        period_compare <= period_shadow; // RQ2 RQ8
        duty_compare <= duty_shadow; // RQ2 RQ8
        clock_select <= clock_select_shadow; // RQ4
      end else begin
        if (wr_period) period_compare <= wr_data;
        if (wr_duty) duty_compare <= wr_data;
        if (wr_clksel) clock_select <= wr_data[`CLKSEL_W-1:0];
      end
      if (wr_counter) channel_counter <= wr_data;
      else if (restart) channel_counter <= {`CNT_W{1'b0}}; // RQ16 RQ17
      else if (step) channel_counter <= channel_counter + {{(`CNT_W-1){1'b0}}, 1'b1};
      // Active level below duty compare
      pwm_level <= run && ((channel_counter < duty_compare) == level_high); // RQ15 RQ17
    end
  end
endmodule // pwm_channel
`default_nettype wire

// ==== testbench/pwm_sync_props.sv ====
// Checker for the APB side and the update-enable readback
`timescale 1ns/1ps
`default_nettype none
`include "pwm_sync_map.vh"
module pwm_shadow_sync_update_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic route_valid,
  input wire logic [1:0] route_channel,
  input wire logic [31:0] route_word,
  input wire logic route_ready,
  input wire logic [`NUM_CH-1:0] pwm_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire glb = acc && paddr == `GRP_GLOBAL;
  logic [7:0] upen;
  // Expected enable states, rebuilt from the writes seen on the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upen <= 8'h00;
    end else if (glb && pwrite) begin
      for (int n = 0; n < 4; n++) begin
        if (pwdata[`GLB_UPEN_LSB+2*n +: 2] == 2'b01) upen[2*n +: 2] <= 2'b00;
        else if (pwdata[`GLB_UPEN_LSB+2*n +: 2] == 2'b10) upen[2*n +: 2] <= 2'b11;
      end
    end
  end
  sequence rd_done;
    acc && !pwrite ##1 !psel;
  endsequence
  AST_PREADY: assert property (acc |-> pready)
    else $error("pready low in access phase");
  AST_ERR_PHASE: assert property (pslverr |-> acc)
    else $error("pslverr outside access phase");
  AST_ERR_ZERO: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_GLB_MAPPED: assert property (glb |-> !pslverr)
    else $error("group control flagged unmapped");
  AST_UPEN_READ: assert property (glb && !pwrite |-> prdata[23:16] == upen)
    else $error("update-enable readback wrong");
  AST_SHADOW_MAPPED: assert property (acc && paddr == `CH_BASE + `CH_PSHADOW |-> !pslverr)
    else $error("period shadow flagged unmapped");
  AST_PRDATA_HOLD: assert property (rd_done |-> $stable(prdata))
    else $error("read data moved without a read");
  AST_ROUTE_READY: assert property (route_valid |-> route_ready)
    else $error("routing word refused");
  AST_QUIET: assert property ($rose(presetn) |-> pwm_out == '0)
    else $error("output active right after reset");
endmodule // pwm_shadow_sync_update_props
bind pwm_shadow_sync_update pwm_shadow_sync_update_props i_pwm_shadow_sync_update_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .route_valid(route_valid), .route_channel(route_channel), .route_word(route_word),
  .route_ready(route_ready), .pwm_out(pwm_out));
`default_nettype wire

// ==== testbench/route_source.sv ====
// Routing unit model handing shadow words to the PWM group
`timescale 1ns/1ps
`default_nettype none
module route_source (
  input wire logic pclk,
  output logic route_valid,
  output logic [1:0] route_channel,
  output logic [31:0] route_word
);
  logic go = 1'b0;
  logic [1:0] ch = 2'h0;
  logic [31:0] word = 32'h0;
  initial begin
    route_valid = 1'b0;
    route_channel = 2'h1;
    route_word = 32'h5a5aa5a5;
  end
  // Idle bus toggles so stale words never look valid
  always @(posedge pclk) begin
    route_valid <= go;
    route_channel <= go ? ch : ~route_channel;
    route_word <= go ? word : ~route_word;
  end
  task automatic send(input logic [1:0] c, input logic [31:0] d);
    ch <= c;
    word <= d;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    // Let an edge pass so a following call never drives go twice at once
    @(posedge pclk);
  endtask
endmodule // route_source
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the PWM shadow update group
`timescale 1ns/1ps
`default_nettype none
`include "pwm_sync_map.vh"
module tb;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata, route_word;
  wire pready, pslverr, route_ready, route_valid;
  wire [1:0] route_channel;
  wire [3:0] pwm_out;
  int failures = 0;
  int comparisons = 0;
  always #2.5 pclk = ~pclk;
  pwm_shadow_sync_update i_pwm_shadow_sync_update (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .route_valid(route_valid),
    .route_channel(route_channel), .route_word(route_word), .route_ready(route_ready),
    .pwm_out(pwm_out));
  route_source i_route_source (.pclk(pclk), .route_valid(route_valid),
    .route_channel(route_channel), .route_word(route_word));
  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1) begin
      failures++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [11:0] chr(input int n, input logic [4:0] off);
    return 12'(`CH_BASE + `CH_STRIDE * n + off);
  endfunction
  task automatic set_pd(input int n, input logic [31:0] du, input logic [31:0] pe);
    apb(1, chr(n, `CH_DUTY), du);
    apb(1, chr(n, `CH_DSHADOW), du);
    apb(1, chr(n, `CH_PERIOD), pe);
    apb(1, chr(n, `CH_PSHADOW), pe);
  endtask
  // Master period is 0x64 + 1 cycles, so any window this long holds one period
  task automatic count_high(input int b);
    rd = 0;
    repeat (101) begin
      @(posedge pclk);
      rd = rd + {31'h0, pwm_out[b]};
    end
  endtask
  task automatic t_upen;
    logic [31:0] wr [3] = '{32'h00aa0000, 32'h00050000, 32'h00f00000};
    logic [31:0] ex [3] = '{32'hff, 32'hf0, 32'hf0};
    for (int i = 0; i < 3; i++) begin
      apb(1, `GRP_GLOBAL, wr[i]);
      apb(0, `GRP_GLOBAL, 32'h0);
      check({24'h0, rd[23:16]}, ex[i]);
    end
    $display("test update enable done");
  endtask
  task automatic t_regs;
    logic [4:0] offs [4] = '{`CH_PERIOD, `CH_DUTY, `CH_PSHADOW, `CH_DSHADOW};
    for (int i = 0; i < 4; i++) begin
      apb(1, chr(1, offs[i]), 32'h1230 + i);
      apb(0, chr(1, offs[i]), 32'h0);
      check(rd, 32'h1230 + i);
    end
    apb(0, 12'h0f0, 32'h0);
    check({rd[30:0], err}, 32'h1);
    $display("test register access done");
  endtask
  task automatic t_force;
    apb(1, chr(3, `CH_PSHADOW), 32'h10);
    apb(1, chr(3, `CH_DSHADOW), 32'h20);
    apb(1, chr(3, `CH_CLKSHADOW), 32'h1);
    apb(0, chr(3, `CH_PERIOD), 32'h0);
    check(rd, 32'h0);
    apb(1, `GRP_GLOBAL, 32'h00aa0001);
    apb(0, chr(3, `CH_PERIOD), 32'h0);
    check(rd, 32'h10);
    apb(0, chr(3, `CH_DUTY), 32'h0);
    check(rd, 32'h20);
    apb(0, chr(3, `CH_CLKSEL), 32'h0);
    check(rd, 32'h1);
    $display("test forced update done");
  endtask
  task automatic t_pwm;
    apb(1, chr(0, `CH_CTRL), 32'h01001800);
    apb(1, chr(1, `CH_CTRL), 32'h00101000);
    apb(1, chr(2, `CH_CTRL), 32'h00101000);
    set_pd(0, 32'h32, 32'h64);
    apb(1, chr(0, `CH_COUNTER), 32'h0);
    set_pd(1, 32'h28, 32'h3c);
    set_pd(2, 32'h26, 32'h3e);
    apb(1, `GRP_OUTPUT_ENABLE_FIELD, 32'haa);
    apb(1, `GRP_CHANNEL_ENABLE_FIELD, 32'h2a);
    apb(1, `GRP_GLOBAL, 32'h00aa0001);
    repeat (300) @(posedge pclk);
    count_high(0);
    check(rd, 32'h32);
    count_high(2);
    check(rd, 32'h4c);
    apb(1, chr(1, `CH_DSHADOW), 32'h2);
    apb(1, chr(1, `CH_PSHADOW), 32'h4c);
    repeat (300) @(posedge pclk);
    count_high(1);
    check(rd, 32'h4);
    count_high(2);
    check(rd, 32'h4c);
    $display("test synchronous pwm done");
  endtask
  task automatic t_route;
    apb(1, `GRP_ROUTE, 32'h4);
    i_route_source.send(2'h2, 32'h00210043);
    i_route_source.send(2'h3, 32'h00550066);
    apb(0, chr(2, `CH_PSHADOW), 32'h0);
    check(rd, 32'h43);
    apb(0, chr(2, `CH_DSHADOW), 32'h0);
    check(rd, 32'h21);
    apb(0, chr(3, `CH_PSHADOW), 32'h0);
    check(rd, 32'h10);
    $display("test routed words done");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_upen();
    t_regs();
    t_force();
    t_pwm();
    t_route();
    final_report();
  end
endmodule // tb
`default_nettype wire
